// file: hw/jie_consts.svh
// Constants for the jump and increment execution block
// Notes on behaviour
// [RULE1] Far jump loads literal into counter bits 20:1
// [RULE2] Literal reaches any word of 2-Mbyte space
// [RULE3] Low literal byte first, bits 19:8 second
// [RULE4] Far jump always two cycles, second is idle
// [RULE5] Plain increment opcode 0010 10da ffff ffff
// [RULE6] Destination bit picks accumulator or register
// [RULE7] Plain increment updates all five flags
// [RULE8] Bank bit picks access bank or selected bank
// [RULE9] Extended set, bank 0, f<=95: indexed offset
// [RULE10] Skip increment opcode 0011 11da ffff ffff
// [RULE11] Skip increment writes result, flags untouched
// [RULE12] Zero result discards the fetched next word
// [RULE13] Skip increment one cycle, two when skipping
// [RULE14] Skipping a two-word instruction costs three
// [RULE15] Far jump clears counter bit zero
`ifndef JIE_CONSTS_SVH
`define JIE_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define JIE_OFF_INSTR   8'h00
`define JIE_OFF_WREG    8'h04
`define JIE_OFF_STATUS  8'h08
`define JIE_OFF_BANK    8'h0c
`define JIE_OFF_PROG    8'h10
`define JIE_OFF_CTRL    8'h14
`define JIE_OFF_INDEX   8'h18
`define JIE_OFF_CYCLES  8'h1c
`define JIE_OFF_MADDR   8'h20
`define JIE_OFF_MDATA   8'h24

// ---------------------------------------------------------------
// Status and control field positions
// ---------------------------------------------------------------
`define JIE_BIT_CARRY   0
`define JIE_BIT_DIGIT   1
`define JIE_BIT_ZERO    2
`define JIE_BIT_SRANGE  3
`define JIE_BIT_NEG     4
`define JIE_BIT_EXT     0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define JIE_RST_WREG    8'h00
`define JIE_RST_STATUS  5'h00
`define JIE_RST_BANK    4'h0
`define JIE_RST_PROG    21'h000000
`define JIE_RST_INDEX   12'h000

// ---------------------------------------------------------------
// Opcode patterns and addressing limits
// ---------------------------------------------------------------
`define JIE_OP_JUMP_LO  8'hef
`define JIE_OP_JUMP_HI  4'hf
`define JIE_OP_INC      6'h0a
`define JIE_OP_INCSKIP  6'h0f
`define JIE_IDX_LIMIT   8'h5f
`define JIE_ACC_SPLIT   8'h80
`define JIE_ACC_HIBANK  4'hf

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define JIE_Q_LAST      2'h3
`define JIE_WORD_STEP   21'h000002

`endif

// file: hw/jie_data_mem.sv
// Data memory with registered read port for the execution block
`timescale 1ns/1ns
module jie_data_mem #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	// Clock
	input  wire logic          pclk,
	// Access port
	input  wire logic [AW-1:0] addr,
	input  wire logic          we,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	// Storage array, no reset: contents are software's to set
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Write on strobe, read data registered every edge
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule

// file: hw/jie_exec.sv
// Execution unit for far jump and two increment instructions
`timescale 1ns/1ns
`include "jie_consts.svh"
module jie_exec
	import jie_pkg::*;
#(
	parameter int AW = 12
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	// ---------------------------------------------------------------
	// State record
	// ---------------------------------------------------------------
	typedef struct packed {
		jie_state_t     st;       // Sequencer state
		logic [1:0]     q;        // Phase within an instruction cycle
		logic [15:0]    word;     // Instruction in execution
		logic [7:0]     lit_lo;   // Low literal of a far jump
		logic           want_hi;  // Far jump second word awaited
		jie_skip_t      skip;     // Discard pending
		logic [7:0]     wreg;     // Accumulator
		logic [4:0]     flags;    // Status flags
		logic [3:0]     bank;     // Bank select
		logic [20:0]    program_counter;
		logic           ext;      // Extended set enabled
		logic [AW-1:0]  idx;      // Indexed offset base
		logic [31:0]    cycles;   // Instruction cycles spent
		logic [AW-1:0]  maddr;    // Software memory pointer
		logic [7:0]     res;      // Increment result
		logic           mwe;      // Memory write strobe
		logic [AW-1:0]  mem_a;    // Memory address
		logic [7:0]     mem_d;    // Memory write data
		logic           pready;   // Bus answer
		logic [31:0]    prdata;   // Bus read data
		logic           pslverr;  // Bus error
	} jie_regs_t;

	jie_regs_t      r_reg;      // Registered state
	jie_regs_t      r_next;     // Next state
	logic [7:0]     mem_rdata;  // Memory read data
	logic           acc;        // Access phase awaiting answer
	logic [15:0]    w;          // Written instruction word
	logic [AW-1:0]  eff_a;      // Effective operand address
	logic           two_word;   // Written word opens two words
	logic           is_inc;     // Plain increment opcode
	logic           is_skip;    // Skip increment opcode
	logic [7:0]     sum;        // Operand plus one

	// ---------------------------------------------------------------
	// Data memory
	// ---------------------------------------------------------------
	jie_data_mem #(
		.AW    (AW),
		.DW    (8)
	) u_mem (
		.pclk  (pclk),
		.addr  (r_reg.mem_a),
		.we    (r_reg.mwe),
		.wdata (r_reg.mem_d),
		.rdata (mem_rdata)
	);

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------

	// Bus handshake and word under decode. The answer flop masks the
	// access phase for the cycle in which pready stands, since the
	// master still shows psel and penable then and the same transfer
	// must not be taken twice.
	assign acc = psel && penable && !r_reg.pready;
	assign w   = pwdata[15:0];

	// Opcode matches on the written word
	assign is_inc  = (w[15:10] == `JIE_OP_INC); // RULE5
	assign is_skip = (w[15:10] == `JIE_OP_INCSKIP); // RULE10

	// Words whose follower is a second literal word. Only the skip
	// logic needs this: a discarded opener must drag its literal word
	// along, or that word would run as an instruction of its own.
	assign two_word = (w[15:12] == 4'hc) ||
		(w[15:9] == 7'h76) ||
		(w[15:8] == `JIE_OP_JUMP_LO) ||
		(w[15:8] == 8'hee);

	// Incremented operand, wraps from ff to 00
	assign sum = mem_rdata + 8'h01;

	// Operand address from bank bit, extended mode and field.
	// Indexed mode only claims the low part of the access bank; the
	// upper part of that bank stays fixed at the top page.
	always_comb begin
		if (w[8]) begin
			eff_a = AW'({r_reg.bank, w[7:0]}); // RULE8
		end else if (r_reg.ext && w[7:0] <= `JIE_IDX_LIMIT) begin
			eff_a = AW'(r_reg.idx + AW'(w[7:0])); // RULE9
		end else if (w[7:0] < `JIE_ACC_SPLIT) begin
			eff_a = AW'({4'h0, w[7:0]}); // RULE8
		end else begin
			eff_a = AW'({`JIE_ACC_HIBANK, w[7:0]}); // RULE8
		end
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		r_next         = r_reg;
		r_next.pready  = 1'b0;
		r_next.pslverr = 1'b0;
		r_next.mwe     = 1'b0;
		unique case (r_reg.st)
			// Waiting for a word or a register access
			JIE_S_FETCH: begin
				if (acc && pwrite) begin
					r_next.pready = 1'b1;
					unique case (paddr)
						`JIE_OFF_INSTR: begin
							r_next.program_counter =
								r_reg.program_counter + `JIE_WORD_STEP;
							if (r_reg.skip == JIE_K_NEXT) begin
								// Fetched word dropped, idle cycle
								r_next.skip = two_word ?
									JIE_K_TAIL : JIE_K_NONE; // RULE14
								r_next.cycles = r_reg.cycles + 32'h1; // RULE12
								r_next.st = JIE_S_NOP;
								r_next.q = 2'h0;
							end else if (r_reg.skip == JIE_K_TAIL) begin
								// Tail word of a skipped pair
								r_next.skip = JIE_K_NONE;
								r_next.cycles = r_reg.cycles + 32'h1; // RULE14
								r_next.st = JIE_S_NOP;
								r_next.q = 2'h0;
							end else if (r_reg.want_hi) begin
								// Second jump word: counter loaded
								r_next.want_hi = 1'b0;
								r_next.program_counter =
									{w[11:0], r_reg.lit_lo, 1'b0}; // RULE1 RULE2 RULE3 RULE15
								r_next.cycles = r_reg.cycles + 32'h2; // RULE4
								r_next.st = JIE_S_NOP;
								r_next.q = 2'h0;
							end else if (w[15:8] == `JIE_OP_JUMP_LO) begin
								// First jump word: hold low literal
								r_next.lit_lo = w[7:0]; // RULE3
								r_next.want_hi = 1'b1;
							end else if (is_inc || is_skip) begin
								// Increment: operand read starts
								r_next.word = w;
								r_next.mem_a = eff_a;
								r_next.cycles = r_reg.cycles + 32'h1; // RULE13
								r_next.st = JIE_S_EXEC;
								r_next.q = 2'h0;
							end else begin
								// Other opcodes pass as one idle cycle
								r_next.cycles = r_reg.cycles + 32'h1;
							end
						end
						`JIE_OFF_WREG: begin
							r_next.wreg = pwdata[7:0];
						end
						`JIE_OFF_STATUS: begin
							r_next.flags = pwdata[4:0];
						end
						`JIE_OFF_BANK: begin
							r_next.bank = pwdata[3:0];
						end
						`JIE_OFF_CTRL: begin
							r_next.ext = pwdata[`JIE_BIT_EXT];
						end
						`JIE_OFF_INDEX: begin
							r_next.idx = pwdata[AW-1:0];
						end
						`JIE_OFF_MADDR: begin
							r_next.maddr = pwdata[AW-1:0];
						end
						`JIE_OFF_MDATA: begin
							// Direct memory write at the pointer
							r_next.mwe = 1'b1;
							r_next.mem_a = r_reg.maddr;
							r_next.mem_d = pwdata[7:0];
						end
						`JIE_OFF_PROG, `JIE_OFF_CYCLES: begin
							// Read-only, write ignored
							r_next.pslverr = 1'b0;
						end
						default: begin
							r_next.pslverr = 1'b1;
						end
					endcase
				end else if (acc) begin
					r_next.pready = 1'b1;
					r_next.prdata = 32'h0;
					unique case (paddr)
						`JIE_OFF_INSTR: begin
							r_next.prdata = {16'h0, r_reg.word};
						end
						`JIE_OFF_WREG: begin
							r_next.prdata = {24'h0, r_reg.wreg};
						end
						`JIE_OFF_STATUS: begin
							r_next.prdata = {27'h0, r_reg.flags};
						end
						`JIE_OFF_BANK: begin
							r_next.prdata = {28'h0, r_reg.bank};
						end
						`JIE_OFF_PROG: begin
							r_next.prdata = {11'h0, r_reg.program_counter};
						end
						`JIE_OFF_CTRL: begin
							r_next.prdata = {31'h0, r_reg.ext};
						end
						`JIE_OFF_INDEX: begin
							r_next.prdata = 32'(r_reg.idx);
						end
						`JIE_OFF_CYCLES: begin
							r_next.prdata = r_reg.cycles;
						end
						`JIE_OFF_MADDR: begin
							r_next.prdata = 32'(r_reg.maddr);
						end
						`JIE_OFF_MDATA: begin
							// Memory read needs two more cycles
							r_next.pready = 1'b0;
							r_next.mem_a = r_reg.maddr;
							r_next.st = JIE_S_MRD;
							r_next.q = 2'h0;
						end
						default: begin
							r_next.pslverr = 1'b1;
						end
					endcase
				end
			end
			// Three phases of an increment. The memory read port is
			// registered, so the address set at decode is answered one
			// edge later: phase 1 is the first one that sees the operand.
			// Phase 2 writes back, then the unit is free again.
			JIE_S_EXEC: begin
				r_next.q = r_reg.q + 2'h1;
				if (r_reg.q == 2'h1) begin
					// Process data and flags
					r_next.res = sum; // RULE6
					if (r_reg.word[15:10] == `JIE_OP_INC) begin
						r_next.flags[`JIE_BIT_CARRY] =
							(mem_rdata == 8'hff); // RULE7
						r_next.flags[`JIE_BIT_DIGIT] =
							(mem_rdata[3:0] == 4'hf); // RULE7
						r_next.flags[`JIE_BIT_ZERO] =
							(sum == 8'h00); // RULE7
						r_next.flags[`JIE_BIT_SRANGE] =
							(mem_rdata == 8'h7f); // RULE7
						r_next.flags[`JIE_BIT_NEG] = sum[7]; // RULE7
					end
				end else if (r_reg.q == 2'h2) begin
					// Write to destination
					if (r_reg.word[9]) begin
						r_next.mwe = 1'b1; // RULE6 RULE11
						r_next.mem_d = r_reg.res;
					end else begin
						r_next.wreg = r_reg.res; // RULE6 RULE11
					end
					if (r_reg.word[15:10] == `JIE_OP_INCSKIP &&
						r_reg.res == 8'h00) begin
						r_next.skip = JIE_K_NEXT; // RULE12 RULE13
					end
					r_next.st = JIE_S_FETCH;
				end
			end
			// Idle instruction cycle. Bus accesses wait through all four
			// phases, so a discarded word costs a full instruction cycle.
			JIE_S_NOP: begin
				r_next.q = r_reg.q + 2'h1;
				if (r_reg.q == `JIE_Q_LAST) begin
					r_next.st = JIE_S_FETCH; // RULE4
				end
			end
			// Software memory read in flight. The address went out at
			// the taking edge; data come back one edge later, then the
			// next edge copies them onto the bus.
			JIE_S_MRD: begin
				r_next.q = r_reg.q + 2'h1;
				if (r_reg.q == 2'h1) begin
					r_next.pready = 1'b1;
					r_next.prdata = {24'h0, mem_rdata};
					r_next.st = JIE_S_FETCH;
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Reset clears the whole record to constants; the memory array is
	// left alone, so software must write a byte before it reads it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{
				st:              JIE_S_FETCH,
				q:               2'h0,
				word:            16'h0000,
				lit_lo:          8'h00,
				want_hi:         1'b0,
				skip:            JIE_K_NONE,
				wreg:            `JIE_RST_WREG,
				flags:           `JIE_RST_STATUS,
				bank:            `JIE_RST_BANK,
				program_counter: `JIE_RST_PROG,
				ext:             1'b0,
				idx:             AW'(`JIE_RST_INDEX),
				cycles:          32'h0,
				maddr:           '0,
				res:             8'h00,
				mwe:             1'b0,
				mem_a:           '0,
				mem_d:           8'h00,
				pready:          1'b0,
				prdata:          32'h0,
				pslverr:         1'b0
			};
		end else begin
			r_reg <= r_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// All three come straight from the record flops, so the bus never
	// sees decode glitches from the next-state logic.
	assign prdata  = r_reg.prdata;
	assign pready  = r_reg.pready;
	assign pslverr = r_reg.pslverr;

endmodule

// file: hw/jie_pkg.sv
// Types shared by the jump and increment execution block
package jie_pkg;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		JIE_S_FETCH = 4'b0001,
		JIE_S_EXEC  = 4'b0010,
		JIE_S_NOP   = 4'b0100,
		JIE_S_MRD   = 4'b1000
	} jie_state_t;

	// Pending discard of fetched words
	typedef enum logic [1:0] {
		JIE_K_NONE  = 2'h0,
		JIE_K_NEXT  = 2'h1,
		JIE_K_TAIL  = 2'h2
	} jie_skip_t;

endpackage

// file: sim/jie_exec_checker.sv
// Port-level checks for the jump and increment execution block
`timescale 1ns/1ns
`include "jie_consts.svh"
module jie_exec_checker (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB slave side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	// Good read answer in this cycle
	wire logic rd_ok = pready && !pwrite && !pslverr;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_answer_bound: assert property (psel && !penable |=> ##[0:30] pready)
		else $error("transfer never answered");
	chk_unmapped_err: assert property
		(pready && paddr > `JIE_OFF_MDATA |-> pslverr)
		else $error("unmapped offset not flagged");
	chk_mapped_ok: assert property
		(pready && paddr <= `JIE_OFF_MDATA && paddr[1:0] == 2'h0
			|-> !pslverr)
		else $error("mapped offset flagged");
	chk_pc_aligned: assert property
		(rd_ok && paddr == `JIE_OFF_PROG |-> prdata[0] == 1'b0)
		else $error("counter bit zero set");
	chk_pc_width: assert property
		(rd_ok && paddr == `JIE_OFF_PROG |-> prdata[31:21] == 11'h000)
		else $error("counter wider than 21 bits");
	chk_wreg_width: assert property
		(rd_ok && paddr == `JIE_OFF_WREG |-> prdata[31:8] == 24'h0)
		else $error("accumulator wider than a byte");
	chk_flag_width: assert property
		(rd_ok && paddr == `JIE_OFF_STATUS |-> prdata[31:5] == 27'h0)
		else $error("flags wider than five bits");

	// Main scenarios
	cover property (pslverr);
	cover property (rd_ok && paddr == `JIE_OFF_PROG);
	cover property (pready && pwrite && paddr == `JIE_OFF_INSTR);
endmodule

bind jie_exec jie_exec_checker chk_u (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// file: sim/jie_exec_tb.sv
// Self-checking bench for the jump and increment execution block
`timescale 1ns/1ns
`include "jie_consts.svh"
module jie_exec_tb;
	// ----
	// Signals and bench state
	// ----
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [33:0] exp_q[$];   // Notes: {check data, error, data}
	logic [33:0] mon_e;      // Note taken by the watcher
	int          fail_count, samples_checked, i;
	logic [15:0] rs;         // Random generator state
	logic [3:0]  bank;       // Expected bank select
	logic        ext;        // Expected extended set enable
	logic [11:0] idx;        // Expected index base
	logic [31:0] cyc;        // Expected cycle count
	logic [19:0] k;          // Jump literal
	logic [7:0]  ftab [4] = '{8'h5f, 8'h60, 8'h80, 8'h05};
	logic [15:0] otab [3] = '{16'hc123, 16'hec05, 16'hee10}; // Openers
	logic [7:0]  rtab [8] = '{`JIE_OFF_WREG, `JIE_OFF_STATUS, `JIE_OFF_BANK,
		`JIE_OFF_PROG, `JIE_OFF_CTRL, `JIE_OFF_INDEX, `JIE_OFF_CYCLES,
		`JIE_OFF_MADDR};

	jie_exec #(.AW(12)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);

	// Clock
	always #50 pclk = ~pclk;

	// ----
	// Helpers
	// ----
	function automatic logic [15:0] rnd();
		rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
		return rs;
	endfunction

	// Data memory address of an operand
	function automatic logic [11:0] ea(logic a, logic [7:0] f);
		if (a) return {bank, f};
		if (ext && f <= 8'h5f) return idx + {4'h0, f};
		if (f < 8'h80) return {4'h0, f};
		return {4'hf, f};
	endfunction

	// Flags after adding one: neg, range, zero, digit, carry
	function automatic logic [4:0] st(logic [7:0] v);
		logic [7:0] r;
		r = v + 8'h01;
		return {r[7], v == 8'h7f, r == 8'h00, v[3:0] == 4'hf, v == 8'hff};
	endfunction

	// One APB transfer; the note goes to the watcher
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
		logic [33:0] e);
		int n;
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Hold the request until pready is seen high at a rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		if (pready !== 1'b1) begin
			fail_count++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] x);
		apb(1'b0, a, 32'h0, {2'b10, x});
	endtask

	task automatic mset(logic [11:0] a, logic [7:0] v);
		wr(`JIE_OFF_MADDR, {20'h0, a});
		wr(`JIE_OFF_MDATA, {24'h0, v});
	endtask

	task automatic mchk(logic [11:0] a, logic [7:0] v);
		wr(`JIE_OFF_MADDR, {20'h0, a});
		rd(`JIE_OFF_MDATA, {24'h0, v});
	endtask

	// Plain increment of one operand
	task automatic inc_case(logic d, logic a, logic [7:0] f, logic [7:0] v);
		logic [11:0] ad;
		logic [15:0] w;
		logic [7:0]  r;
		ad = ea(a, f);
		w = {6'h0a, d, a, f};
		r = v + 8'h01;
		mset(ad, v);
		wr(`JIE_OFF_INSTR, {16'h0, w});
		cyc++;
		if (d) mchk(ad, r);
		else begin
			rd(`JIE_OFF_WREG, {24'h0, r});
			mchk(ad, v);
		end
		rd(`JIE_OFF_STATUS, {27'h0, st(v)});
		rd(`JIE_OFF_INSTR, {16'h0, w});
		rd(`JIE_OFF_CYCLES, cyc);
	endtask

	// Increment with skip, then the words that follow it
	task automatic skip_case(logic z, logic two);
		logic [7:0] v;
		logic [4:0] s0;
		v = 8'(rnd());
		v = z ? 8'hff : {v[7:1], 1'b0};
		s0 = 5'(rnd());
		wr(`JIE_OFF_CTRL, 32'h0);
		ext = 1'b0;
		mset(12'h030, v);
		mset(12'h031, 8'h10);
		wr(`JIE_OFF_STATUS, {27'h0, s0});
		wr(`JIE_OFF_INSTR, 32'h3e30);
		cyc++;
		rd(`JIE_OFF_STATUS, {27'h0, s0});
		mchk(12'h030, v + 8'h01);
		if (two) begin
			wr(`JIE_OFF_INSTR, 32'hef45);
			wr(`JIE_OFF_INSTR, 32'hf123);
			cyc += 2;
			if (!z) rd(`JIE_OFF_PROG, 32'h2468a);
		end
		wr(`JIE_OFF_INSTR, 32'h2a31);
		cyc++;
		mchk(12'h031, (z && !two) ? 8'h10 : 8'h11);
		rd(`JIE_OFF_CYCLES, cyc);
	endtask

	task automatic wrap_up();
		$display("mismatches %0d, checks %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Watcher: compares each answer with the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			mon_e = exp_q.pop_front();
			samples_checked++;
			if (pslverr !== mon_e[32] ||
				(mon_e[33] && prdata !== mon_e[31:0])) begin
				fail_count++;
				$display("wrong value at %0t: addr %h got %h err %b",
					$time, paddr, prdata, pslverr);
			end
		end
	end

	// ----
	// Main sequence
	// ----
	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rs = 16'd59048;
		{fail_count, samples_checked, cyc} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values
		for (i = 0; i < 8; i++) rd(rtab[i], 32'h0);
		bank = 4'h5;
		idx = 12'h3a0;
		wr(`JIE_OFF_BANK, 32'h5);
		wr(`JIE_OFF_INDEX, {20'h0, idx});
		// Plain increments over bank, index and destination choices
		for (i = 0; i < 16; i++) begin
			ext = i[3];
			wr(`JIE_OFF_CTRL, {31'h0, ext});
			inc_case(i[0] ^ i[1], i[2], ftab[i[1:0]],
				i == 0 ? 8'hff : i == 1 ? 8'h7f : 8'(rnd()));
		end
		// Skip increments: zero or not, one- or two-word follower
		for (i = 0; i < 4; i++) skip_case(i[0], i[1]);
		// Zero skips over the other two-word openers: the tail word is
		// an increment that must be dropped, the next one must run
		for (i = 0; i < 3; i++) begin
			mset(12'h030, 8'hff);
			mset(12'h031, 8'h10);
			wr(`JIE_OFF_INSTR, 32'h3e30);
			wr(`JIE_OFF_INSTR, {16'h0, otab[i]});
			wr(`JIE_OFF_INSTR, 32'h2a31);
			wr(`JIE_OFF_INSTR, 32'h2a31);
			cyc += 4;
			mchk(12'h031, 8'h11);
			rd(`JIE_OFF_CYCLES, cyc);
		end
		// Opcodes outside the three take one idle cycle
		wr(`JIE_OFF_INSTR, 32'h0000);
		cyc++;
		rd(`JIE_OFF_CYCLES, cyc);
		// Far jumps, top literal first
		for (i = 0; i < 3; i++) begin
			k = (i == 0) ? 20'hfffff : 20'({rnd(), rnd()});
			wr(`JIE_OFF_INSTR, {16'h0, 8'hef, k[7:0]});
			wr(`JIE_OFF_INSTR, {16'h0, 4'hf, k[19:8]});
			cyc += 2;
			rd(`JIE_OFF_PROG, {11'h0, k, 1'b0});
			rd(`JIE_OFF_CYCLES, cyc);
		end
		// Refused and ignored accesses
		apb(1'b0, 8'h28, 32'h0, {2'b01, 32'h0});
		apb(1'b1, 8'hfc, 32'h0, {2'b01, 32'h0});
		wr(`JIE_OFF_PROG, 32'hffffffff);
		rd(`JIE_OFF_PROG, {11'h0, k, 1'b0});
		wr(`JIE_OFF_BANK, 32'hffffffff);
		rd(`JIE_OFF_BANK, 32'hf);
		wrap_up();
	end
endmodule
